//--- verilog/fed_pkg.sv
// Purpose: constants and types for the SPI frame error detector.
// Assumes: mclk_i at 40 MHz; serial clock idles high, at most 5 MHz.
// Notes: serial addresses are six bits, as carried in the packet.
// Function
// - Frame error flag is bit 9 of error_flags, serial pair 0x24:0x25.
// - Set the flag when a frame's clock edge count is not a packet length.
// - Set the flag when the first MOSI bit of a frame is one.
// - Manchester path frame errors set the same flag.
// - Idle falling clock edges spoil the next frame's count; flag then set.
// - With 16-bit packets any idle low clock sets the flag.
// - Early edge after a read may discard it; reply uses last valid read.
// - 16-bit late edge after a read keeps it; next reply may be corrupt.
// - 20-bit late edge after a read leaves the read intact.
// - Early edge after a write may discard the write.
// - Late edge after a write performs it; in 16-bit mode it still sets the flag.
// - 20-bit idle edges may set the flag falsely, rarely.
// - 21-bit packets ignore idle clock edges.
// - After power-up each idle device flags once; host clears flags.
// - 21-bit MISO: 16 data, 4 CRC, CRC MSB repeated; host skips it.
package fed_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [5:0] ADDR_ERR_HI = 6'h24;
    localparam logic [5:0] ADDR_ERR_LO = 6'h25;
    localparam int ERR_FRAME_BIT = 9;
    localparam logic [15:0] ERR_RESET = 16'h0000;

    // ************************************************************
    // Packet lengths and shifter sizes
    // ************************************************************
    localparam int PKT_W = 21;
    localparam logic [4:0] LEN16 = 5'h10;
    localparam logic [4:0] LEN20 = 5'h14;
    localparam logic [4:0] LEN21 = 5'h15;
    localparam logic [4:0] CNT_MAX = 5'h1f;
    localparam int WR_BIT = 14;

    // ************************************************************
    // Timing: the early-edge window after chip select rises
    // ************************************************************
    localparam int CLK_MHZ = 40;
    localparam int T_LATE_NS = 70;
    localparam int LATE_CYC = (T_LATE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [2:0] LATE_CNT = 3'(LATE_CYC);

    // ************************************************************
    // Reply checksum
    // ************************************************************
    localparam logic [3:0] CRC_POLY = 4'h3;
    localparam logic [3:0] CRC_INIT = 4'hf;

    typedef enum logic [2:0] {
        MODE16 = 3'b001,
        MODE20 = 3'b010,
        MODE21 = 3'b100
    } pkt_mode_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FRAME = 3'b010,
        ST_HOLD = 3'b100
    } fsm_type;

    // Serial checksum over the sixteen reply bits, MSB first.
    function automatic logic [3:0] crc4(input logic [15:0] d);
        logic [3:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            fb = c[3] ^ d[i];
            c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
        end
        return c;
    endfunction

endpackage

//--- verilog/shift_if.sv
// Purpose: carrier between frame control and the serial shifter.
// Assumes: all signals on mclk_i.
// Notes: edges are one-cycle pulses from synchronised pins.
`timescale 1ns/1ps
interface shift_if;
    logic sclk_rise;
    logic sclk_fall;
    logic sel;
    logic mosi;
    logic load;
    logic idle_shift;
    logic [fed_pkg::PKT_W-1:0] load_word;
    logic [fed_pkg::PKT_W-1:0] rx;
    logic [4:0] cnt;
    logic tx_bit;

    modport ctrl (
        output sclk_rise, sclk_fall, sel, mosi, load, idle_shift, load_word,
        input rx, cnt, tx_bit
    );
    modport shft (
        input sclk_rise, sclk_fall, sel, mosi, load, idle_shift, load_word,
        output rx, cnt, tx_bit
    );
endinterface

//--- verilog/pin_sync.sv
// Purpose: two-flop synchroniser for the serial pins.
// Assumes: inputs are asynchronous to clk_i.
// Notes: only the second stage leaves the module.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 3
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_type;

    sync_type r;
    sync_type n;

    // Reset to all ones: chip select and clock idle high.
    always_comb begin
        n.s1 = d_i;
        n.s2 = r.s1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            r <= '1;
        end else begin
            r <= n;
        end
    end

    assign q_o = r.s2;
endmodule // pin_sync

//--- verilog/spi_shifter.sv
// Purpose: receive and transmit shift registers with edge counter.
// Assumes: edge pulses already synchronised to clk_i.
// Notes: an idle shift lets stray clocks walk the reply out of place.
`timescale 1ns/1ps
module spi_shifter (
    input wire logic clk_i,
    input wire logic rst_b_i,
    shift_if.shft s
);
    typedef struct packed {
        logic [fed_pkg::PKT_W-1:0] rx;
        logic [fed_pkg::PKT_W-1:0] tx;
        logic [4:0] cnt;
    } shreg_type;

    shreg_type r;
    shreg_type n;

    // Load clears the frame; MOSI enters on rising edges, MISO moves on
    // falling edges once the frame has begun, so the MSB survives a
    // leading falling edge.
    always_comb begin
        n = r;
        if (s.load) begin
            n.tx = s.load_word;
            n.rx = '0;
            n.cnt = '0;
        end else begin
            if (s.sel && s.sclk_rise) begin
                n.rx = {r.rx[fed_pkg::PKT_W-2:0], s.mosi};
                if (r.cnt != fed_pkg::CNT_MAX) begin
                    n.cnt = r.cnt + 5'h01;
                end
            end
            if (s.sclk_fall &&
                ((s.sel && r.cnt != 5'h00) || s.idle_shift)) begin
                n.tx = {r.tx[fed_pkg::PKT_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign s.rx = r.rx;
    assign s.cnt = r.cnt;
    assign s.tx_bit = r.tx[fed_pkg::PKT_W-1];
endmodule // spi_shifter

//--- verilog/spi_frame_error_detector.sv
// Purpose: SPI peripheral frame checking with the error flag register.
// Assumes: host drives chip select, clock and MOSI; clock may be shared.
// Notes: packet length is learned from each well-formed frame.
`timescale 1ns/1ps
module spi_frame_error_detector (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic cs_b_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic manch_frame_err_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic frame_error_flag_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        fed_pkg::fsm_type st;
        fed_pkg::pkt_mode_type mode;
        logic sclk_q;
        logic [15:0] err;
        logic [5:0] rd_addr;
        logic idle_bad;
        logic [2:0] win;
        logic cmd_ok;
        logic cmd_wr;
        logic [5:0] cmd_addr;
        logic [7:0] cmd_data;
        logic load;
        logic oe;
    } state_type;

    // start in 16-bit mode so idle edges count until a length is seen
    localparam state_type RST = '{
        st: fed_pkg::ST_IDLE,
        mode: fed_pkg::MODE16,
        sclk_q: 1'b1,
        err: fed_pkg::ERR_RESET,
        rd_addr: 6'h00,
        idle_bad: 1'b0,
        win: 3'h0,
        cmd_ok: 1'b0,
        cmd_wr: 1'b0,
        cmd_addr: 6'h00,
        cmd_data: 8'h00,
        load: 1'b0,
        oe: 1'b0
    };

    state_type r;
    state_type n;
    logic [2:0] pins;
    logic sel;
    logic fall;
    logic rise;
    logic len_ok;
    logic [15:0] word;
    logic msb;
    fed_pkg::pkt_mode_type len_mode;
    logic frame_end;
    logic set_flag;
    logic commit;
    logic do_cmd;
    logic [15:0] clr;
    logic [15:0] resp;
    logic [3:0] crc;

    shift_if sh ();

    // ************************************************************
    // Pins and shifter
    // ************************************************************
    pin_sync #(
        .W(3)
    ) u_sync (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .d_i({cs_b_i, sclk_i, mosi_i}),
        .q_o(pins)
    );

    spi_shifter u_shift (
        .clk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .s(sh.shft)
    );

    // Edges come from the synchronised level against its last value.
    assign sel = !pins[2];
    assign fall = r.sclk_q && !pins[1];
    assign rise = !r.sclk_q && pins[1];
    assign frame_end = (r.st == fed_pkg::ST_FRAME) && !sel;

    // reply is data, checksum, then the checksum MSB once more
    assign resp = (r.rd_addr == fed_pkg::ADDR_ERR_HI ||
                   r.rd_addr == fed_pkg::ADDR_ERR_LO) ? r.err : 16'h0000;
    assign crc = fed_pkg::crc4(resp);

    assign sh.sclk_rise = rise;
    assign sh.sclk_fall = fall;
    assign sh.sel = sel;
    assign sh.mosi = pins[0];
    assign sh.load = r.load;
    assign sh.load_word = {resp, crc, crc[3]};
    // only 16-bit mode lets idle edges walk the loaded reply
    // 20-bit and 21-bit replies stay put between frames
    assign sh.idle_shift = (r.mode == fed_pkg::MODE16) && !sel;

    // ************************************************************
    // Packet decode
    // ************************************************************
    // a 21-bit frame is the 20-bit frame shifted one place left
    always_comb begin
        len_ok = 1'b1;
        len_mode = fed_pkg::MODE16;
        word = sh.rx[15:0];
        if (sh.cnt == fed_pkg::LEN21) begin
            len_mode = fed_pkg::MODE21;
            word = sh.rx[20:5];
        end else if (sh.cnt == fed_pkg::LEN20) begin
            len_mode = fed_pkg::MODE20;
            word = sh.rx[19:4];
        end else if (sh.cnt != fed_pkg::LEN16) begin
            len_ok = 1'b0;
        end
        msb = word[15];
    end

    // ************************************************************
    // Frame control and error register
    // ************************************************************
    // Commands wait out the early-edge window before they take effect,
    // because an edge inside it means the frame itself may be damaged.
    always_comb begin
        n = r;
        n.sclk_q = pins[1];
        n.load = 1'b0;
        n.oe = sel;
        // Manchester frame errors share the flag
        set_flag = manch_frame_err_i;
        commit = 1'b0;
        clr = 16'h0000;
        unique case (r.st)
            fed_pkg::ST_IDLE: begin
                // any idle low clock in 16-bit mode spoils the count
                if (fall && r.mode == fed_pkg::MODE16) begin
                    n.idle_bad = 1'b1;
                end
                if (sel) begin
                    n.st = fed_pkg::ST_FRAME;
                end
            end
            fed_pkg::ST_FRAME: begin
                if (!sel) begin
                    n.st = fed_pkg::ST_HOLD;
                    n.win = fed_pkg::LATE_CNT;
                    // coincident edge drops command
                    // A stray edge close behind chip select reaches the
                    // synchronisers with it, so it must count as early.
                    n.cmd_ok = len_ok && !msb && !fall;
                    n.cmd_wr = word[fed_pkg::WR_BIT];
                    n.cmd_addr = word[13:8];
                    n.cmd_data = word[7:0];
                    n.idle_bad = fall && (r.mode != fed_pkg::MODE21);
                    // wrong count; leading one; idle edges
                    if (!len_ok || msb || r.idle_bad) begin
                        set_flag = 1'b1;
                    end
                    if (len_ok) begin
                        n.mode = len_mode;
                    end
                end
            end
            fed_pkg::ST_HOLD: begin
                n.win = r.win - 3'h1;
                if (fall) begin
                    // an early edge drops the pending command
                    n.cmd_ok = 1'b0;
                    // 20-bit mode only flags edges in this window
                    // 21-bit mode never flags idle edges
                    if (r.mode != fed_pkg::MODE21) begin
                        n.idle_bad = 1'b1;
                    end
                end
                if (r.win == 3'h1 || sel) begin
                    commit = 1'b1;
                    n.load = 1'b1;
                    n.st = sel ? fed_pkg::ST_FRAME : fed_pkg::ST_IDLE;
                end
            end
            default: begin
                n = RST;
            end
        endcase
        do_cmd = commit && r.cmd_ok && !fall;
        if (do_cmd && r.cmd_wr) begin
            // a late edge does not stop the write; in 16-bit mode the flag comes later
            if (r.cmd_addr == fed_pkg::ADDR_ERR_HI) begin
                clr = {r.cmd_data, 8'h00};
            end else if (r.cmd_addr == fed_pkg::ADDR_ERR_LO) begin
                clr = {8'h00, r.cmd_data};
            end
        end else if (do_cmd) begin
            // a discarded read leaves the last valid address in place
            n.rd_addr = r.cmd_addr;
        end
        // write-one-to-clear only, and a new event beats the clear
        n.err = r.err & ~clr;
        // the flag lives at bit 9 of the error register
        if (set_flag) begin
            n.err[fed_pkg::ERR_FRAME_BIT] = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    // The reply bit is a shifter flop; enable and flag are local flops.
    assign miso_o = sh.tx_bit;
    assign miso_oe_o = r.oe;
    assign frame_error_flag_o = r.err[fed_pkg::ERR_FRAME_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_hold_run;
        frame_end ##1 (!sel)[*3];
    endsequence

    sequence s_early_read;
        (r.st == fed_pkg::ST_HOLD) && fall && !r.cmd_wr;
    endsequence

    a_count_flag:
    assert property (frame_end && !len_ok |=> frame_error_flag_o)
        else $error("Bad edge count did not set the flag.");

    a_msb_flag:
    assert property (frame_end && len_ok && msb |=> r.err[9])
        else $error("Leading one did not set the flag.");

    a_manch_flag:
    assert property (manch_frame_err_i |=> frame_error_flag_o)
        else $error("Manchester error did not set the flag.");

    a_idle_report:
    assert property (frame_end && r.idle_bad |=> r.err[9] &&
                     (r.idle_bad == $past(fall &&
                                          (r.mode != fed_pkg::MODE21))))
        else $error("Idle edges were not reported at frame end.");

    a_idle_count:
    assert property ((r.st == fed_pkg::ST_IDLE) && fall &&
                     (r.mode == fed_pkg::MODE16) |=> r.idle_bad)
        else $error("Idle edge in 16-bit mode was not recorded.");

    a_ignore_idle:
    assert property ((r.st == fed_pkg::ST_IDLE) &&
                     (r.mode == fed_pkg::MODE21) && !r.idle_bad
                     |=> !r.idle_bad)
        else $error("Idle edge counted in 21-bit mode.");

    a_sticky_flag:
    assert property (r.err[9] && !(do_cmd && clr[9]) |=> r.err[9])
        else $error("Flag cleared without a software clear.");

    a_read_discard:
    assert property (s_early_read |=> $stable(r.rd_addr) [*2])
        else $error("Early edge did not discard the read.");

    a_load_after:
    assert property (s_hold_run |=> r.load ##1 !r.load)
        else $error("Reply not loaded after the window.");

    a_late_write:
    assert property ((r.st == fed_pkg::ST_HOLD) && r.cmd_ok && r.cmd_wr &&
                     (r.win == 3'h1) && !fall && !sel && !set_flag &&
                     (r.cmd_addr == fed_pkg::ADDR_ERR_HI) && r.cmd_data[1]
                     |=> !r.err[9])
        else $error("Late write was not performed.");

    a_bit9_map:
    assert property (r.load && (r.rd_addr == fed_pkg::ADDR_ERR_HI)
                     |-> sh.load_word[14] == frame_error_flag_o)
        else $error("Reply bit 9 does not carry the flag.");

endmodule // spi_frame_error_detector

//--- bench/spi_host.sv
// Purpose: host controller model that drives the serial link.
// Assumes: serial clock idles high and runs with a 200 ns period.
// Notes: stray clock pulses are sent only when the bench asks for one.
`timescale 1ns/1ps
module spi_host (
    output logic cs_b_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i
);
    // Idle state: deselected, clock high.
    initial begin
        cs_b_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b1;
    end

    // ************************************************************
    // Frame transfer
    // ************************************************************
    // Sends n bits MSB first from word[20]; reply bits land from rx[20]
    // down. A stray falling edge follows chip select by gap_ns when
    // gap_ns is above zero, as a clock shared with a neighbour would.
    task automatic frame(input logic [20:0] word, input int n,
                         input int gap_ns, output logic [20:0] rx);
        rx = 21'h000000;
        cs_b_o = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b0;
            mosi_o = word[20-i];
            #100;
            sclk_o = 1'b1;
            rx[20-i] = miso_i;
            #100;
        end
        cs_b_o = 1'b1;
        // Released data line flips so no stale bit can pass for data.
        mosi_o = ~mosi_o;
        if (gap_ns > 0) begin
            #(gap_ns);
            sclk_o = 1'b0;
            #100;
            sclk_o = 1'b1;
        end
        #600;
    endtask
endmodule // spi_host

//--- bench/test_spi_frame_error_detector.sv
// Purpose: self-checking bench for the SPI frame error detector.
// Assumes: host model drives the link; commands pipeline their replies.
// Notes: a reply is the register named by the previous committed read.
`timescale 1ns/1ps
module test_spi_frame_error_detector;
    localparam logic [15:0] NOP = 16'h0000;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic manch_err = 1'b0;
    logic cs_b;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic flag;
    logic [20:0] rx;
    int n_errors = 0;
    int checks_done = 0;
    int bad_len[3] = '{8, 17, 19};
    int good_len[3] = '{16, 20, 21};

    // Clock of 40 MHz.
    always #12.5 mclk = ~mclk;

    spi_frame_error_detector i_dut (
        .mclk_i(mclk),
        .rst_b_i(rst_b),
        .cs_b_i(cs_b),
        .sclk_i(sclk),
        .mosi_i(mosi),
        .manch_frame_err_i(manch_err),
        .miso_o(miso),
        .miso_oe_o(miso_oe),
        .frame_error_flag_o(flag)
    );

    spi_host i_host (
        .cs_b_o(cs_b),
        .sclk_o(sclk),
        .mosi_o(mosi),
        .miso_i(miso)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_flag(input logic exp);
        check("frame error flag", {15'h0000, exp}, {15'h0000, flag});
    endtask

    // Sync bit, write bit, address, data.
    function automatic logic [15:0] cmd(input logic wr, input logic [5:0] a,
                                        input logic [7:0] d);
        return {1'b0, wr, a, d};
    endfunction

    task automatic xfer(input logic [15:0] w, input int n, input int gap);
        i_host.frame({w, 5'h00}, n, gap, rx);
    endtask

    task automatic clear_flag(input int n, input int gap);
        xfer(cmd(1'b1, fed_pkg::ADDR_ERR_HI, 8'h02), n, gap);
    endtask

    task automatic manch_pulse();
        @(posedge mclk);
        #1;
        manch_err = 1'b1;
        @(posedge mclk);
        #1;
        manch_err = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge mclk);
        // Keep every later pin change and sample off the clock edge.
        #1;
        chk_flag(1'b0);
        check("miso enable", 16'h0000, {15'h0000, miso_oe});
        // A late idle edge spoils the count of the following frame.
        xfer(NOP, 16, 200);
        chk_flag(1'b0);
        xfer(NOP, 16, 0);
        chk_flag(1'b1);
        clear_flag(16, 0);
        chk_flag(1'b0);
        xfer(16'h8000, 16, 0);
        chk_flag(1'b1);
        xfer(cmd(1'b1, fed_pkg::ADDR_ERR_LO, 8'hff), 16, 0);
        chk_flag(1'b1);
        xfer(cmd(1'b0, fed_pkg::ADDR_ERR_HI, 8'h00), 16, 0);
        xfer(NOP, 16, 0);
        check("error_flags", 16'h0200, rx[20:5]);
        clear_flag(16, 0);
        chk_flag(1'b0);
        foreach (bad_len[k]) begin
            xfer(NOP, bad_len[k], 0);
            chk_flag(1'b1);
            clear_flag(16, 0);
        end
        foreach (good_len[k]) begin
            xfer(NOP, good_len[k], 0);
            chk_flag(1'b0);
        end
        xfer(NOP, 16, 0);
        manch_pulse();
        chk_flag(1'b1);
        clear_flag(16, 10);
        chk_flag(1'b1);
        xfer(cmd(1'b0, fed_pkg::ADDR_ERR_HI, 8'h00), 16, 0);
        xfer(NOP, 16, 40);
        xfer(NOP, 16, 0);
        check("reply after drop", 16'h0200, rx[20:5]);
        clear_flag(16, 200);
        chk_flag(1'b0);
        xfer(NOP, 16, 0);
        chk_flag(1'b1);
        // A late idle edge walks the 16-bit reply one place ahead.
        xfer(cmd(1'b0, fed_pkg::ADDR_ERR_HI, 8'h00), 16, 200);
        xfer(NOP, 16, 0);
        check("reply 16 shifted", 16'h0400, {rx[20:6], 1'b0});
        xfer(NOP, 20, 0);
        xfer(cmd(1'b0, fed_pkg::ADDR_ERR_HI, 8'h00), 20, 200);
        xfer(NOP, 20, 0);
        check("reply 20 bit", 16'h0200, rx[20:5]);
        clear_flag(20, 200);
        xfer(NOP, 20, 0);
        chk_flag(1'b0);
        xfer(cmd(1'b0, fed_pkg::ADDR_ERR_HI, 8'h00), 21, 200);
        xfer(NOP, 21, 0);
        check("reply 21 bit", 16'h0000, rx[20:5]);
        chk_flag(1'b0);
        check("crc repeat", {15'h0000, rx[4]}, {15'h0000, rx[0]});
        end_of_test();
    end

    // Whole run is near 140 us; this bound leaves ample margin.
    initial begin
        #500000;
        n_errors++;
        end_of_test();
    end
endmodule // test_spi_frame_error_detector
